// ---- logic/amw_pkg.sv ----
package amw_pkg;
    // register byte offsets
    localparam logic [3:0] RAW_STATUS_OFS    = 4'h0;
    localparam logic [3:0] MASKED_STATUS_OFS = 4'h4;
    localparam logic [3:0] ENABLE_SET_OFS    = 4'h8;
    localparam logic [3:0] ENABLE_CLEAR_OFS  = 4'hc;
    // field positions
    localparam int TIMEOUT_BIT   = 0;
    localparam int WAIT_RISE_BIT = 2;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam int BUS_ADDR_W = 4;
endpackage : amw_pkg

// ---- logic/amw_irq_status.sv ----
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
// Operation
// [R01] wait pin rising edge sets raw bit 2
// [R02] extended-wait timeout sets raw bit 0
// [R03] raw flags set regardless of enables
// [R04] write 1 raw wait-rise clears both
// [R05] write 1 raw timeout clears both
// [R06] writing 0 to flags changes nothing
// [R07] masked flags set only when enabled
// [R08] masked flag set sends interrupt pulse
// [R09] write 1 masked flag clears both
// [R10] reserved status bits read zero
// [R11] disabled interrupt: masked zero, no pulse
// [R12] enable-set write 1 enables interrupt
// [R13] enable-clear write 1 disables; 0 ignored
// [R14] one enable state read at both
// [R15] reset zero; event beats clear
// [R16] wait pin synchronised before edge detect
module amw_irq_status
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_ext_wait_in,
    input  wire logic        i_timeout_evt,
    output logic             o_irq_pulse
);
    localparam int WR = amw_pkg::WAIT_RISE_BIT;
    localparam int TO = amw_pkg::TIMEOUT_BIT;

    logic       wait_meta_q;
    logic       wait_sync_q;
    logic       wait_prev_q;
    logic       rise_evt;
    logic [1:0] evt;
    logic [1:0] raw_q;
    logic [1:0] masked_q;
    logic [1:0] enable_q;
    logic       ack_q;
    logic [31:0] rdata_q;
    logic       irq_q;

    // picks status bits {wait_rise, timeout} out of a bus word
    function automatic logic [1:0] flag_bits(input logic [31:0] w);
        flag_bits = {w[amw_pkg::WAIT_RISE_BIT], w[amw_pkg::TIMEOUT_BIT]};
    endfunction : flag_bits

    function automatic logic [31:0] flag_word(input logic [1:0] f);
        flag_word = amw_pkg::REG_RESET;
        flag_word[amw_pkg::WAIT_RISE_BIT] = f[1];
        flag_word[amw_pkg::TIMEOUT_BIT]   = f[0];
    endfunction : flag_word

    // pin is asynchronous to i_ref_clk
    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            wait_meta_q <= 1'b0;
            wait_sync_q <= 1'b0;
            wait_prev_q <= 1'b0;
        end
        else
        begin
            wait_meta_q <= i_ext_wait_in;
            wait_sync_q <= wait_meta_q; // see [R16]
            wait_prev_q <= wait_sync_q;
        end
    end

    assign rise_evt = wait_sync_q & ~wait_prev_q; // see [R01] see [R16]
    assign evt      = {rise_evt, i_timeout_evt}; // see [R02]

    // one-cycle wait state: accepted write/read is the second cycle
    logic acc;
    logic wr_acc;
    logic [1:0] w1c;
    assign acc    = (i_avs_read | i_avs_write) & ack_q;
    assign wr_acc = i_avs_write & ack_q & i_avs_byteenable[0];
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            ack_q <= 1'b0;
        else
            ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
    end

    // a 1 in either status register clears raw and masked together
    always_comb
    begin
        w1c = 2'b00;
        if (wr_acc && (i_avs_address == amw_pkg::RAW_STATUS_OFS
                       || i_avs_address == amw_pkg::MASKED_STATUS_OFS))
            w1c = flag_bits(i_avs_writedata); // see [R04] see [R05] see [R09] see [R06]
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            raw_q <= 2'b00; // see [R15]
        else
            raw_q <= (raw_q & ~w1c) | evt; // see [R03] see [R15]
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            masked_q <= 2'b00;
        else
            masked_q <= (masked_q & ~w1c & enable_q) | (evt & enable_q); // see [R07] see [R11]
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            enable_q <= 2'b00;
        else if (wr_acc && i_avs_address == amw_pkg::ENABLE_SET_OFS)
            enable_q <= enable_q | flag_bits(i_avs_writedata); // see [R12]
        else if (wr_acc && i_avs_address == amw_pkg::ENABLE_CLEAR_OFS)
            enable_q <= enable_q & ~flag_bits(i_avs_writedata); // see [R13]
    end

    // pulse on each new masked event, not on a level
    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            irq_q <= 1'b0;
        else
            irq_q <= |(evt & enable_q); // see [R08] see [R11]
    end
    assign o_irq_pulse = irq_q;

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            rdata_q <= amw_pkg::REG_RESET;
        else if (i_avs_read && !ack_q)
        begin
            case (i_avs_address)
                amw_pkg::RAW_STATUS_OFS:    rdata_q <= flag_word(raw_q); // see [R10]
                amw_pkg::MASKED_STATUS_OFS: rdata_q <= flag_word(masked_q);
                amw_pkg::ENABLE_SET_OFS:    rdata_q <= flag_word(enable_q); // see [R14]
                amw_pkg::ENABLE_CLEAR_OFS:  rdata_q <= flag_word(enable_q); // see [R14]
                default:                    rdata_q <= amw_pkg::REG_RESET;
            endcase
        end
    end
    assign o_avs_readdata = rdata_q;

    // counts waitrequest cycles in a row; a stretched wait state would stall the cpu
    logic [1:0] wait_run_q;

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            wait_run_q <= 2'b00;
        else if (!o_avs_waitrequest)
            wait_run_q <= 2'b00;
        else if (wait_run_q != 2'b11)
            wait_run_q <= wait_run_q + 2'b01;
    end

    // pin seen high by the first stage only: the edge is one cycle away
    sequence s_pin_fresh;
        wait_meta_q && !wait_sync_q && !wait_prev_q;
    endsequence

    sequence s_pin_rise;
        s_pin_fresh ##1 rise_evt;
    endsequence

    sequence s_bus_hold;
        (i_avs_read || i_avs_write) && o_avs_waitrequest ##1 (i_avs_read || i_avs_write);
    endsequence

    a_raw_wr_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R01]
        rise_evt
        |=> raw_q[1])
        else $error("wait rise not recorded");

    a_pin_path: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R01]
        s_pin_rise
        |=> raw_q[1])
        else $error("pin rise lost on the way to the raw flag");

    a_raw_to_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R02]
        i_timeout_evt
        |=> raw_q[0])
        else $error("timeout not recorded");

    a_raw_free_wr: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R03]
        (rise_evt && !enable_q[1])
        |=> raw_q[1])
        else $error("raw wait rise gated by enable");

    a_raw_free_to: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R03]
        (i_timeout_evt && !enable_q[0])
        |=> raw_q[0])
        else $error("raw timeout gated by enable");

    a_clear_both: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R04]
        (w1c[1] && !evt[1])
        |=> !raw_q[1] && !masked_q[1])
        else $error("w1c did not clear both");

    a_clear_to: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R05]
        (w1c[0] && !evt[0])
        |=> !raw_q[0] && !masked_q[0])
        else $error("w1c timeout failed");

    a_zero_keep: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R06]
        (raw_q[0] && !w1c[0])
        |=> raw_q[0])
        else $error("flag lost");

    a_zero_keep_wr: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R06]
        (raw_q[1] && !w1c[1])
        |=> raw_q[1])
        else $error("wait rise flag lost");

    a_masked_keep: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R06]
        (masked_q[1] && !w1c[1] && enable_q[1])
        |=> masked_q[1])
        else $error("masked wait rise lost");

    a_masked_wr_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R07]
        (rise_evt && enable_q[1])
        |=> masked_q[1])
        else $error("enabled wait rise not masked in");

    a_masked_to_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R07]
        (i_timeout_evt && enable_q[0])
        |=> masked_q[0])
        else $error("enabled timeout not masked in");

    a_irq_wr: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R08]
        (rise_evt && enable_q[1])
        |=> o_irq_pulse)
        else $error("no pulse for wait rise");

    a_irq_to: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R08]
        (i_timeout_evt && enable_q[0])
        |=> o_irq_pulse)
        else $error("no pulse for timeout");

    a_irq_cause: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R08]
        o_irq_pulse
        |-> $past(|(evt & enable_q)))
        else $error("spurious irq");

    a_mask_clr_wr: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R09]
        (wr_acc && i_avs_address == amw_pkg::MASKED_STATUS_OFS
         && i_avs_writedata[WR] && !evt[1])
        |=> !raw_q[1] && !masked_q[1])
        else $error("masked wait rise clear missed raw");

    a_mask_clr_to: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R09]
        (wr_acc && i_avs_address == amw_pkg::MASKED_STATUS_OFS
         && i_avs_writedata[TO] && !evt[0])
        |=> !raw_q[0] && !masked_q[0])
        else $error("masked timeout clear missed raw");

    a_rsv_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R10]
        (o_avs_readdata & ~flag_word(2'b11)) == amw_pkg::REG_RESET)
        else $error("reserved read bit set");

    a_masked_gate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R11]
        !enable_q[0]
        |=> !masked_q[0])
        else $error("masked set while disabled");

    a_masked_gate_wr: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R11]
        !enable_q[1]
        |=> !masked_q[1])
        else $error("masked wait rise while disabled");

    a_irq_quiet: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R11]
        (enable_q == 2'b00)
        |=> !o_irq_pulse)
        else $error("pulse with all disabled");

    a_en_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R12]
        (wr_acc && i_avs_address == amw_pkg::ENABLE_SET_OFS && i_avs_writedata[WR])
        |=> enable_q[1])
        else $error("enable set failed");

    a_en_set_to: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R12]
        (wr_acc && i_avs_address == amw_pkg::ENABLE_SET_OFS && i_avs_writedata[TO])
        |=> enable_q[0])
        else $error("timeout enable set failed");

    a_en_clr: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R13]
        (wr_acc && i_avs_address == amw_pkg::ENABLE_CLEAR_OFS && i_avs_writedata[TO])
        |=> !enable_q[0])
        else $error("enable clear failed");

    a_en_clr_wr: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R13]
        (wr_acc && i_avs_address == amw_pkg::ENABLE_CLEAR_OFS && i_avs_writedata[WR])
        |=> !enable_q[1])
        else $error("wait rise enable clear failed");

    a_en_clr_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R13]
        (wr_acc && i_avs_address == amw_pkg::ENABLE_CLEAR_OFS && !i_avs_writedata[WR])
        |=> enable_q[1] == $past(enable_q[1]))
        else $error("zero write changed enable");

    a_en_alias: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R14]
        (i_avs_read && !ack_q && (i_avs_address == amw_pkg::ENABLE_SET_OFS
                                  || i_avs_address == amw_pkg::ENABLE_CLEAR_OFS))
        |=> o_avs_readdata == flag_word($past(enable_q)))
        else $error("enable view differs");

    a_set_wins: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R15]
        (w1c[1] && evt[1])
        |=> raw_q[1])
        else $error("clear beat event");

    a_set_wins_to: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R15]
        (w1c[0] && evt[0])
        |=> raw_q[0])
        else $error("clear beat timeout");

    a_sync_edge: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R16]
        s_pin_fresh
        |=> rise_evt)
        else $error("synchronised edge missed");

    a_rise_once: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see [R16]
        rise_evt
        |=> !rise_evt)
        else $error("one pin edge seen twice");

    a_bus_wait: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        s_bus_hold
        |-> !o_avs_waitrequest)
        else $error("held request not answered");

    a_wait_short: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        wait_run_q < 2'b10)
        else $error("wait state longer than one cycle");

    a_acc_ready: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        acc
        |-> !o_avs_waitrequest)
        else $error("accepted while waiting");
endmodule : amw_irq_status

// ---- verif/amw_far_model.sv ----
`timescale 1ns/1ps
module amw_far_model
(
    input  wire logic i_ref_clk,
    input  wire logic i_irq_pulse,
    output logic      o_ext_wait_in,
    output logic      o_timeout_evt,
    output int        o_irq_count
);
    initial
    begin
        o_ext_wait_in = 1'b0;
        o_timeout_evt = 1'b0;
        o_irq_count   = 0;
    end
    // each pulse counted once, a stretched pulse would show as extra counts
    always @(posedge i_ref_clk)
        if (i_irq_pulse === 1'b1)
            o_irq_count <= o_irq_count + 1;
    // pin held high for several edges: one rise only must be seen
    task automatic wait_rise();
        @(posedge i_ref_clk) o_ext_wait_in <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        o_ext_wait_in <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
    endtask : wait_rise
    task automatic timeout();
        @(posedge i_ref_clk) o_timeout_evt <= 1'b1;
        @(posedge i_ref_clk) o_timeout_evt <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
    endtask : timeout
endmodule : amw_far_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic        i_ref_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdata;
    logic        wreq;
    logic        ext_wait;
    logic        tmo;
    logic        irq;
    int          irq_count;
    int          n_errors = 0;
    int          tests_run = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    amw_irq_status dut_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_ext_wait_in(ext_wait),
        .i_timeout_evt(tmo), .o_irq_pulse(irq));
    amw_far_model far_u (.i_ref_clk(i_ref_clk), .i_irq_pulse(irq), .o_ext_wait_in(ext_wait),
        .o_timeout_evt(tmo), .o_irq_count(irq_count));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= !w;
        do
        begin
            @(posedge i_ref_clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q  = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20)
        begin
            n_errors++;
            stop_test();
        end
    endtask : bus
    task automatic rc(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q, exp);
    endtask : rc
    task automatic wt(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wt
    initial
    begin
        repeat (10) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) rc(4'(i * 4), amw_pkg::REG_RESET);
        $display("test reset done");
        far_u.timeout();
        rc(4'h0, 32'h0000_0001);
        rc(4'h4, 32'h0000_0000);
        chk(32'(irq_count), 32'h0000_0000);
        wt(4'h8, 32'h0000_0005);
        rc(4'h8, 32'h0000_0005);
        rc(4'hc, 32'h0000_0005);
        far_u.wait_rise();
        rc(4'h0, 32'h0000_0005);
        rc(4'h4, 32'h0000_0004);
        chk(32'(irq_count), 32'h0000_0001);
        $display("test events done");
        wt(4'h0, 32'h0000_0000);
        wt(4'h4, 32'h0000_0000);
        rc(4'h0, 32'h0000_0005);
        wt(4'h4, 32'h0000_0004);
        rc(4'h0, 32'h0000_0001);
        far_u.timeout();
        rc(4'h4, 32'h0000_0001);
        chk(32'(irq_count), 32'h0000_0002);
        wt(4'h0, 32'h0000_0001);
        rc(4'h4, 32'h0000_0000);
        far_u.wait_rise();
        wt(4'h0, 32'h0000_0004);
        rc(4'h4, 32'h0000_0000);
        rc(4'h0, 32'h0000_0000);
        $display("test clearing done");
        wt(4'hc, 32'h0000_0004);
        rc(4'h8, 32'h0000_0001);
        far_u.wait_rise();
        rc(4'h4, 32'h0000_0000);
        chk(32'(irq_count), 32'h0000_0003);
        rc(4'h2, 32'h0000_0000);
        $display("test masking done");
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        rc(4'h8, 32'h0000_0000);
        rc(4'h0, 32'h0000_0000);
        $display("test mid reset done");
        stop_test();
    end
endmodule : testbench
